// [design/pit_pkg.sv]
// ----------------------------------------------------------------------------
// shared constants of the prescaled interval timer
// ----------------------------------------------------------------------------
package pit_pkg;

  // bus geometry
  localparam int unsigned ADR_W = 8;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned SEL_W = 4;

  // counter widths
  localparam int unsigned CNT_W = 16;
  localparam int unsigned SCL_W = 8;

  // register byte offsets
  localparam logic [ADR_W-1:0] OFS_COUNT  = 8'h00;
  localparam logic [ADR_W-1:0] OFS_SCALE  = 8'h04;
  localparam logic [ADR_W-1:0] OFS_PERIOD = 8'h08;
  localparam logic [ADR_W-1:0] OFS_CTRL   = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_STAT   = 8'h10;
  localparam logic [ADR_W-1:0] OFS_MASK   = 8'h14;

  // field positions
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned STAT_EXP_BIT = 0;

  // values after reset
  localparam logic [CNT_W-1:0] RST_COUNT  = 16'h0000;
  localparam logic [SCL_W-1:0] RST_SCALE  = 8'h00;
  localparam logic [CNT_W-1:0] RST_PERIOD = 16'h0000;
  localparam logic             RST_EN     = 1'b0;
  localparam logic             RST_STAT   = 1'b0;
  localparam logic             RST_MASK   = 1'b0;

endpackage : pit_pkg

// [design/pit_timer.sv]
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none

module pit_timer (
  input  wire logic                      clk_i,     // 10 MHz clock
  input  wire logic                      rst_i,     // sync reset, high
  input  wire logic                      wb_cyc_i,  // bus cycle
  input  wire logic                      wb_stb_i,  // strobe
  input  wire logic                      wb_we_i,   // write enable
  input  wire logic [pit_pkg::ADR_W-1:0] wb_adr_i,  // byte address
  input  wire logic [pit_pkg::SEL_W-1:0] wb_sel_i,  // byte lanes
  input  wire logic [pit_pkg::DAT_W-1:0] wb_dat_i,  // write data
  output logic      [pit_pkg::DAT_W-1:0] wb_dat_o,  // read data
  output logic                           wb_ack_o,  // acknowledge
  output logic                           irq_o      // level interrupt
);
  import pit_pkg::*;

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic [CNT_W-1:0] count_r;
  logic [SCL_W-1:0] scale_r;
  logic [CNT_W-1:0] period_r;
  logic [SCL_W-1:0] presc_r;
  logic             en_r;
  logic             stat_r;
  logic             mask_r;
  logic             req;
  logic             wr;
  logic             tick;
  logic             expire;
  logic             wr_count;
  logic             wr_scale;
  logic             wr_period;
  logic             wr_ctrl;
  logic             wr_stat;
  logic             wr_mask;
  logic [DAT_W-1:0] rd_nxt;

  // --------------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------------
  // answer one cycle after the request, never back to back on the same one
  assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // a write lands on the edge where the master takes the acknowledge
  assign wr        = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign wr_count  = wr && (wb_adr_i == OFS_COUNT);
  assign wr_scale  = wr && (wb_adr_i == OFS_SCALE);
  assign wr_period = wr && (wb_adr_i == OFS_PERIOD);
  assign wr_ctrl   = wr && (wb_adr_i == OFS_CTRL);
  assign wr_stat   = wr && (wb_adr_i == OFS_STAT);
  assign wr_mask   = wr && (wb_adr_i == OFS_MASK);

  // prescaler expiry and main count reaching zero
  assign tick   = en_r && (presc_r == '0);
  assign expire = tick && (count_r == '0);

  // --------------------------------------------------------------------------
  // acknowledge
  // --------------------------------------------------------------------------
  // unmapped addresses are still acknowledged so the master never hangs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // read mux, unmapped and unused bits read zero
  always_comb begin
    rd_nxt = '0;
    unique case (wb_adr_i)
      OFS_COUNT:  rd_nxt[CNT_W-1:0]    = count_r;
      OFS_SCALE:  rd_nxt[SCL_W-1:0]    = scale_r;
      OFS_PERIOD: rd_nxt[CNT_W-1:0]    = period_r;
      OFS_CTRL:   rd_nxt[CTRL_EN_BIT]  = en_r;
      OFS_STAT:   rd_nxt[STAT_EXP_BIT] = stat_r;
      OFS_MASK:   rd_nxt[STAT_EXP_BIT] = mask_r;
      default:    rd_nxt               = '0;
    endcase
  end

  // read data captured with the acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= rd_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------------
  // byte lanes honoured; only the low two lanes carry bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scale_r  <= RST_SCALE;
      period_r <= RST_PERIOD;
      en_r     <= RST_EN;
      mask_r   <= RST_MASK;
    end else begin
      if (wr_scale && wb_sel_i[0]) begin
        scale_r <= wb_dat_i[SCL_W-1:0];
      end
      if (wr_period && wb_sel_i[0]) begin
        period_r[7:0] <= wb_dat_i[7:0];
      end
      if (wr_period && wb_sel_i[1]) begin
        period_r[15:8] <= wb_dat_i[15:8];
      end
      if (wr_ctrl && wb_sel_i[0]) begin
        en_r <= wb_dat_i[CTRL_EN_BIT];
      end
      if (wr_mask && wb_sel_i[0]) begin
        mask_r <= wb_dat_i[STAT_EXP_BIT];
      end
    end
  end

  // --------------------------------------------------------------------------
  // prescaler
  // --------------------------------------------------------------------------
  // period is scale+1 cycles; a scale write restarts the current interval
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_r <= RST_SCALE;
    end else if (wr_scale && wb_sel_i[0]) begin
      presc_r <= wb_dat_i[SCL_W-1:0];
    end else if (!en_r) begin
      presc_r <= scale_r;
    end else if (tick) begin
      presc_r <= scale_r;
    end else begin
      presc_r <= presc_r - 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // main down-counter
  // --------------------------------------------------------------------------
  // software write wins over the count step in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= RST_COUNT;
    end else if (wr_count && (wb_sel_i[1:0] != 2'b00)) begin
      if (wb_sel_i[0]) count_r[7:0]  <= wb_dat_i[7:0];
      if (wb_sel_i[1]) count_r[15:8] <= wb_dat_i[15:8];
    end else if (expire) begin
      count_r <= period_r;
    end else if (tick) begin
      count_r <= count_r - 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // interrupt status and output
  // --------------------------------------------------------------------------
  // sticky, write one to clear; a new expiry beats the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_r <= RST_STAT;
    end else if (expire) begin
      stat_r <= 1'b1;
    end else if (wr_stat && wb_sel_i[0] && wb_dat_i[STAT_EXP_BIT]) begin
      stat_r <= 1'b0;
    end
  end

  // registered so the pin never glitches; costs one cycle of latency
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= stat_r && mask_r;
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_expiry;
    expire && !(wr_stat && wb_dat_i[STAT_EXP_BIT]);
  endsequence

  sequence s_flag_then_irq;
    stat_r ##1 (irq_o == $past(mask_r));
  endsequence

  AST_COUNT_STEP: assert property (
    (tick && count_r != '0 && !wr_count) |=> (count_r == $past(count_r) - 1'b1))
    else $error("count did not step down by one on a prescaler expiry");

  AST_COUNT_HOLD: assert property (
    (!tick && !wr_count) |=> $stable(count_r))
    else $error("count moved without a prescaler expiry");

  AST_PRESC_RELOAD: assert property (
    (tick && !wr_scale) |=> (presc_r == $past(scale_r)))
    else $error("prescaler did not reload from the scale value");

  AST_EXPIRY_FLAG: assert property (
    s_expiry |=> s_flag_then_irq)
    else $error("expiry did not set the flag and drive the interrupt");

  AST_PERIOD_RELOAD: assert property (
    (expire && !wr_count) |=> (count_r == $past(period_r)))
    else $error("count did not reload from the period at zero");

  AST_SINGLE_ACK: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer was not a single cycle acknowledge");

  AST_PRESC_STEP: assert property (
    (en_r && presc_r != '0 && !wr_scale) |=> (presc_r == $past(presc_r) - 1'b1))
    else $error("prescaler did not step down while running");

  AST_TICK_ONLY_ZERO: assert property (
    (en_r && presc_r != '0 && !wr_count) |=> $stable(count_r))
    else $error("count changed before the prescaler expired");

  AST_IRQ_GATE: assert property (
    !mask_r [*2] |-> !irq_o)
    else $error("masked status reached the interrupt output");

endmodule : pit_timer

`default_nettype wire

// [verification/pit_timer_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none

module pit_timer_tb_top;
  import pit_pkg::*;
  logic             clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [SEL_W-1:0] sel = '0;
  logic [DAT_W-1:0] wdat = '0, q, q2;
  logic [DAT_W-1:0] wb_dat_o;
  logic             wb_ack_o, irq_o;
  int               error_cnt = 0, total_checks = 0, seed = 9, cyc_n = 0;
  int               s, p, t1, t2;
  logic [ADR_W-1:0] ofs [3] = '{OFS_COUNT, OFS_SCALE, OFS_PERIOD};
  logic [DAT_W-1:0] msk [3] = '{32'h0000FFFF, 32'h000000FF, 32'h0000FFFF};
  logic [DAT_W-1:0] wv [3];
  logic [SEL_W-1:0] lanes = 4'hF;

  pit_timer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o));

  // ------------------------------------------------------------------
  // clock, cycle count, watchdog
  // ------------------------------------------------------------------
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc_n <= cyc_n + 1;
  // generous bound: the run needs well under 20k cycles
  initial begin
    #(100 * 60000);
    error_cnt++;
    conclude();
  end

  // ------------------------------------------------------------------
  // bus and check helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [DAT_W-1:0] got, input logic [DAT_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // classic cycle: hold until ack is sampled, take data at that edge
  task automatic xfer(input logic w, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d,
                      output logic [DAT_W-1:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= lanes;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 100);
    r = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 100) chk(32'hDEAD, 32'h0);
  endtask : xfer

  task automatic wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
    logic [DAT_W-1:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr

  // bounded wait for the interrupt level, returns the cycle it was seen
  task automatic wait_irq(output int t);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (irq_o !== 1'b1 && n < 4000);
    t = cyc_n;
    chk({31'h0, irq_o}, 32'h1);
  endtask : wait_irq

  function automatic int expiry_gap(input int sc, input int pr);
    return (pr + 1) * (sc + 1);
  endfunction : expiry_gap

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, unmapped place reads zero and ignores writes
    for (int i = 0; i < 6; i++) begin
      xfer(1'b0, 8'(4 * i), 32'h0, q);
      chk(q, 32'h0);
    end
    wr(8'h18, 32'hFFFFFFFF);
    xfer(1'b0, 8'h18, 32'h0, q);
    chk(q, 32'h0);
    // read back random values while stopped
    for (int i = 0; i < 3; i++) begin
      wv[i] = $random(seed);
      wr(ofs[i], wv[i]);
      xfer(1'b0, ofs[i], 32'h0, q);
      chk(q, wv[i] & msk[i]);
    end
    // frozen while disabled
    repeat (20) @(posedge clk_i);
    xfer(1'b0, OFS_COUNT, 32'h0, q2);
    chk(q2, wv[0] & msk[0]);
    // a lane left off keeps its byte
    lanes <= 4'h2;
    wr(OFS_PERIOD, 32'h0000C3C3);
    wr(OFS_SCALE, 32'h0000005A);
    lanes <= 4'hF;
    xfer(1'b0, OFS_PERIOD, 32'h0, q);
    chk(q, {16'h0, 8'hC3, wv[2][7:0]});
    xfer(1'b0, OFS_SCALE, 32'h0, q);
    chk(q, wv[1] & msk[1]);
    // periodic expiry with random prescale and period
    for (int k = 0; k < 4; k++) begin
      s = {$random(seed)} % 4;
      p = 6 + {$random(seed)} % 6;
      if (k == 0) s = 0;
      if (k == 3) s = 255;
      wr(OFS_CTRL, 32'h0);
      wr(OFS_SCALE, 32'(s));
      wr(OFS_PERIOD, 32'(p));
      wr(OFS_COUNT, 32'h0);
      wr(OFS_STAT, 32'h1);
      wr(OFS_MASK, 32'h1);
      wr(OFS_CTRL, 32'h1);
      wait_irq(t1);
      // bus traffic in between must not disturb the count
      wr(OFS_STAT, 32'h1);
      // clear lands on the ack edge, the pin follows one edge later
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h0);
      wait_irq(t2);
      chk(32'(t2 - t1), 32'(expiry_gap(s, p)));
      wr(OFS_STAT, 32'h1);
    end
    // masked expiry: status sticks, interrupt stays low
    wr(OFS_MASK, 32'h0);
    repeat (expiry_gap(s, p) + 4) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    xfer(1'b0, OFS_STAT, 32'h0, q);
    chk(q, 32'h1);
    wr(OFS_MASK, 32'h1);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    conclude();
  end
endmodule : pit_timer_tb_top

`default_nettype wire
